// *** core/switch_link_debug_control.sv ***
`timescale 1ns/100ps
`default_nettype none
module switch_link_debug_control (
    input  wire logic                       ref_clk_i,
    input  wire logic                       rst_n_i,
    // Register port
    input  wire logic [switch_ctl_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [31:0]                reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic [31:0]                     reg_rdata_o,
    // Switch-wide write lock level
    input  wire logic                       write_lock_i,
    // Debug request pin, open drain
    input  wire logic                       debug_req_n_i,
    output logic                            debug_req_n_out_o,
    output logic                            debug_req_n_oe_o,
    input  wire logic                       debug_mode_i,
    input  wire logic                       tile_debug_i,
    output logic                            debug_call_trap_o,
    // External link routing status (by letter)
    input  wire logic [2*switch_ctl_pkg::NUM_XL-1:0] xl_dest_type_i,
    input  wire logic [8*switch_ctl_pkg::NUM_XL-1:0] xl_dest_num_i,
    input  wire logic [switch_ctl_pkg::NUM_XL-1:0]   xl_junk_i,
    input  wire logic [switch_ctl_pkg::NUM_XL-1:0]   xl_route_out_i,
    input  wire logic [switch_ctl_pkg::NUM_XL-1:0]   xl_route_in_i,
    output logic [4*switch_ctl_pkg::NUM_XL-1:0]      xl_direction_o,
    output logic [2*switch_ctl_pkg::NUM_XL-1:0]      xl_network_o,
    // Processor link routing status
    input  wire logic [2*switch_ctl_pkg::NUM_PL-1:0] pl_dest_type_i,
    input  wire logic [8*switch_ctl_pkg::NUM_PL-1:0] pl_dest_num_i,
    input  wire logic [switch_ctl_pkg::NUM_PL-1:0]   pl_junk_i,
    input  wire logic [switch_ctl_pkg::NUM_PL-1:0]   pl_route_out_i,
    input  wire logic [switch_ctl_pkg::NUM_PL-1:0]   pl_route_in_i,
    output logic [2*switch_ctl_pkg::NUM_PL-1:0]      pl_network_o,
    // External link setup (by letter)
    input  wire logic [switch_ctl_pkg::NUM_XL-1:0]   link_err_i,
    input  wire logic [switch_ctl_pkg::NUM_XL-1:0]   link_credit_issued_i,
    input  wire logic [switch_ctl_pkg::NUM_XL-1:0]   link_credit_recv_i,
    input  wire logic [switch_ctl_pkg::NUM_XL-1:0]   link_credit_spent_i,
    output logic [switch_ctl_pkg::NUM_XL-1:0]        link_enable_o,
    output logic [switch_ctl_pkg::NUM_XL-1:0]        link_five_wire_o,
    output logic [switch_ctl_pkg::NUM_XL-1:0]        link_tx_allow_o,
    output logic [switch_ctl_pkg::NUM_XL-1:0]        link_greeting_token_o,
    output logic [switch_ctl_pkg::NUM_XL-1:0]        link_rx_reset_o,
    output logic [11*switch_ctl_pkg::NUM_XL-1:0]     link_sym_gap_o,
    output logic [11*switch_ctl_pkg::NUM_XL-1:0]     link_tok_gap_o
);
    import switch_ctl_pkg::*;

    // ---------------------------------------------
    // Access decode
    // ---------------------------------------------
    logic       cfg_wr;      // Write that is not locked
    logic       hit_dcfg;    // Debug pin config
    logic       hit_dsrc;    // Debug source
    logic       hit_xst;     // External status group
    logic       hit_pst;     // Processor status group
    logic       hit_xcf;     // External setup group
    logic [2:0] slot;        // Slot within a group
    logic [2:0] slot_link;   // Link letter of that slot

    // Writes obey the switch-wide lock
    assign cfg_wr    = reg_wr_i & ~write_lock_i;
    assign slot      = reg_addr_i[2:0];
    assign hit_dcfg  = (reg_addr_i == DBG_CFG_IDX);
    assign hit_dsrc  = (reg_addr_i == DBG_SRC_IDX);
    // Group bases are aligned on eight entries
    assign hit_xst   = (reg_addr_i[7:3] == XL_STAT_IDX[7:3]);
    assign hit_xcf   = (reg_addr_i[7:3] == XL_CFG_IDX[7:3]);
    // Only four processor entries exist
    assign hit_pst   = (reg_addr_i[7:2] == PL_STAT_IDX[7:2]);
    // Fixed slot order C,D,B,A,G,H,E,F
    assign slot_link = SLOT_LINK[3*slot +: 3];

    // ---------------------------------------------
    // Debug request pin
    // ---------------------------------------------
    logic trap_en_q;     // Pin may raise a trap
    logic pull_en_q;     // Pull pin low in debug
    logic pin_meta_q;    // First sync stage
    logic pin_sync_q;    // Second sync stage
    logic pin_prev_q;    // Last synced level
    logic pin_event;     // Falling edge seen
    logic src_pin_q;     // Pin caused last event
    logic src_tile_q;    // Tile caused last event

    // Debug config register
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trap_en_q <= 1'b0;
            pull_en_q <= 1'b0;
        end else if (cfg_wr && hit_dcfg) begin
            trap_en_q <= reg_wdata_i[DBG_TRAP_BIT];
            pull_en_q <= reg_wdata_i[DBG_PULL_BIT];
        end
    end

    // Bring the pin into the clock domain
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta_q <= 1'b1;
            pin_sync_q <= 1'b1;
            pin_prev_q <= 1'b1;
        end else begin
            pin_meta_q <= debug_req_n_i;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // A falling edge is not counted as a request while our pull-down is on
    assign pin_event = pin_prev_q & ~pin_sync_q & ~debug_req_n_oe_o;

    // Pull the wire low only while in debug mode
    assign debug_req_n_out_o = 1'b0;
    assign debug_req_n_oe_o  = pull_en_q & debug_mode_i;

    // Trap pulse on pin activity when enabled
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            debug_call_trap_o <= 1'b0;
        end else begin
            debug_call_trap_o <= trap_en_q & pin_event;
        end
    end

    // Latest source; hardware events beat a write
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_pin_q  <= 1'b0;
            src_tile_q <= 1'b0;
        end else if (pin_event || tile_debug_i) begin
            src_pin_q  <= pin_event;
            src_tile_q <= tile_debug_i;
        end else if (cfg_wr && hit_dsrc) begin
            src_pin_q  <= reg_wdata_i[SRC_PIN_BIT];
            src_tile_q <= reg_wdata_i[SRC_TILE_BIT];
        end
    end

    // ---------------------------------------------
    // Per external link state
    // ---------------------------------------------
    logic [3:0]       dir_q   [NUM_XL];  // Direction
    logic [1:0]       xnet_q  [NUM_XL];  // Network
    logic             en_q    [NUM_XL];  // Enabled
    logic             wire_q  [NUM_XL];  // Five wire
    logic             err_q   [NUM_XL];  // Sticky error
    logic             cred_q  [NUM_XL];  // Local credit
    logic             greet_q [NUM_XL];  // Init pulse
    logic             rxr_q   [NUM_XL];  // Rx reset pulse
    logic [GAP_W-1:0] sym_q   [NUM_XL];  // In-token gap
    logic [GAP_W-1:0] tok_q   [NUM_XL];  // Token gap
    logic [1:0]       pnet_q  [NUM_PL];  // Proc network

    genvar g;
    generate
        for (g = 0; g < NUM_XL; g++) begin : gen_xl
            logic st_wr;   // Status write for link g
            logic cf_wr;   // Setup write for link g
            logic cf_rd;   // Setup read for link g
            assign st_wr = cfg_wr & hit_xst & (slot_link == 3'(g));
            assign cf_wr = cfg_wr & hit_xcf & (slot_link == 3'(g));
            assign cf_rd = reg_rd_i & hit_xcf & (slot_link == 3'(g));

            // Routing direction and network
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    dir_q[g]  <= DIR_RST;
                    xnet_q[g] <= NET_RST;
                end else if (st_wr) begin
                    dir_q[g]  <= reg_wdata_i[ST_DIR_LSB +: 4];
                    xnet_q[g] <= reg_wdata_i[ST_NET_LSB +: 2];
                end
            end

            // Link enable, width and timing
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    en_q[g]   <= 1'b0;
                    wire_q[g] <= 1'b0;
                    sym_q[g]  <= GAP_RST;
                    tok_q[g]  <= GAP_RST;
                end else if (cf_wr) begin
                    en_q[g]   <= reg_wdata_i[CF_EN_BIT];
                    wire_q[g] <= reg_wdata_i[CF_WIRE_BIT];
                    sym_q[g]  <= reg_wdata_i[CF_SYM_LSB +: GAP_W];
                    tok_q[g]  <= reg_wdata_i[CF_TOK_LSB +: GAP_W];
                end
            end

            // Self-clearing init and receiver reset pulses
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    greet_q[g] <= 1'b0;
                    rxr_q[g]   <= 1'b0;
                end else begin
                    greet_q[g] <= cf_wr & reg_wdata_i[CF_INIT_BIT];
                    rxr_q[g]   <= cf_wr & reg_wdata_i[CF_RXR_BIT];
                end
            end

            // Error flag: event wins over read clear
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    err_q[g] <= 1'b0;
                end else if (link_err_i[g]) begin
                    err_q[g] <= 1'b1;
                end else if (cf_rd) begin
                    err_q[g] <= 1'b0;
                end
            end

            // Local credit: remote grant wins over clears
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cred_q[g] <= 1'b0;
                end else if (link_credit_recv_i[g]) begin
                    cred_q[g] <= 1'b1;
                end else if (cf_wr && reg_wdata_i[CF_INIT_BIT]) begin
                    cred_q[g] <= 1'b0;
                end else if (link_credit_spent_i[g]) begin
                    cred_q[g] <= 1'b0;
                end
            end

            // Drive the link logic
            assign xl_direction_o[4*g +: 4]  = dir_q[g];
            assign xl_network_o[2*g +: 2]    = xnet_q[g];
            assign link_enable_o[g]          = en_q[g];
            assign link_five_wire_o[g]       = wire_q[g];
            // No transmit without credit on an enabled link
            assign link_tx_allow_o[g]        = en_q[g] & cred_q[g];
            assign link_greeting_token_o[g]  = greet_q[g];
            assign link_rx_reset_o[g]        = rxr_q[g];
            assign link_sym_gap_o[11*g +: 11] = sym_q[g];
            assign link_tok_gap_o[11*g +: 11] = tok_q[g];
        end

        // Processor link network numbers
        for (g = 0; g < NUM_PL; g++) begin : gen_pl
            logic pn_wr;   // Write for processor link g
            assign pn_wr = cfg_wr & hit_pst & (slot[1:0] == 2'(g));
            always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    pnet_q[g] <= NET_RST;
                end else if (pn_wr) begin
                    pnet_q[g] <= reg_wdata_i[ST_NET_LSB +: 2];
                end
            end
            assign pl_network_o[2*g +: 2] = pnet_q[g];
        end
    endgenerate

    // ---------------------------------------------
    // Read mux
    // ---------------------------------------------
    logic [31:0] rd_word;   // Word for current address
    logic [1:0]  pl;        // Processor link index

    assign pl = slot[1:0];

    // Assemble the addressed word, reserved bits zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_dcfg) begin
            rd_word[DBG_TRAP_BIT] = trap_en_q;
            rd_word[DBG_PULL_BIT] = pull_en_q;
        end else if (hit_dsrc) begin
            rd_word[SRC_PIN_BIT]  = src_pin_q;
            rd_word[SRC_TILE_BIT] = src_tile_q;
        end else if (hit_xst) begin
            rd_word[ST_TYPE_LSB +: 2] =
                xl_dest_type_i[2*slot_link +: 2];
            rd_word[ST_DEST_LSB +: 8] =
                xl_dest_num_i[8*slot_link +: 8];
            rd_word[ST_DIR_LSB +: 4] = dir_q[slot_link];
            rd_word[ST_NET_LSB +: 2] = xnet_q[slot_link];
            rd_word[ST_JUNK_BIT] = xl_junk_i[slot_link];
            rd_word[ST_OUT_BIT]  = xl_route_out_i[slot_link];
            rd_word[ST_IN_BIT]   = xl_route_in_i[slot_link];
        end else if (hit_pst) begin
            rd_word[ST_TYPE_LSB +: 2] = pl_dest_type_i[2*pl +: 2];
            rd_word[ST_DEST_LSB +: 8] = pl_dest_num_i[8*pl +: 8];
            rd_word[ST_NET_LSB +: 2]  = pnet_q[pl];
            rd_word[ST_JUNK_BIT] = pl_junk_i[pl];
            rd_word[ST_OUT_BIT]  = pl_route_out_i[pl];
            rd_word[ST_IN_BIT]   = pl_route_in_i[pl];
        end else if (hit_xcf) begin
            rd_word[CF_EN_BIT]   = en_q[slot_link];
            rd_word[CF_WIRE_BIT] = wire_q[slot_link];
            rd_word[CF_ERR_BIT]  = err_q[slot_link];
            rd_word[CF_ISS_BIT]  =
                link_credit_issued_i[slot_link];
            rd_word[CF_CRED_BIT] = cred_q[slot_link];
            rd_word[CF_SYM_LSB +: GAP_W] = sym_q[slot_link];
            rd_word[CF_TOK_LSB +: GAP_W] = tok_q[slot_link];
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_word;
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

endmodule // switch_link_debug_control
`default_nettype wire

// *** core/switch_ctl_pkg.sv ***
package switch_ctl_pkg;
    // ---------------------------------------------
    // Sizes
    // ---------------------------------------------
    localparam int NUM_XL = 8;   // External links
    localparam int NUM_PL = 4;   // Processor links
    localparam int ADDR_W = 8;   // Register index width
    localparam int GAP_W  = 11;  // Token timing fields
    // ---------------------------------------------
    // Register indices
    // ---------------------------------------------
    localparam logic [7:0] DBG_CFG_IDX = 8'h10;
    localparam logic [7:0] DBG_SRC_IDX = 8'h1f;
    localparam logic [7:0] XL_STAT_IDX = 8'h20;
    localparam logic [7:0] PL_STAT_IDX = 8'h40;
    localparam logic [7:0] XL_CFG_IDX  = 8'h80;
    // Slot to link letter (A=0 .. H=7), 3 bits a slot
    localparam logic [23:0] SLOT_LINK = 24'hb3e05a;
    // ---------------------------------------------
    // Field positions
    // ---------------------------------------------
    localparam int DBG_TRAP_BIT = 1;
    localparam int DBG_PULL_BIT = 0;
    localparam int SRC_PIN_BIT  = 4;
    localparam int SRC_TILE_BIT = 0;
    localparam int ST_TYPE_LSB  = 24;
    localparam int ST_DEST_LSB  = 16;
    localparam int ST_DIR_LSB   = 8;
    localparam int ST_NET_LSB   = 4;
    localparam int ST_JUNK_BIT  = 2;
    localparam int ST_OUT_BIT   = 1;
    localparam int ST_IN_BIT    = 0;
    localparam int CF_EN_BIT    = 31;
    localparam int CF_WIRE_BIT  = 30;
    localparam int CF_ERR_BIT   = 27;
    localparam int CF_ISS_BIT   = 26;
    localparam int CF_CRED_BIT  = 25;
    localparam int CF_INIT_BIT  = 24;
    localparam int CF_RXR_BIT   = 23;
    localparam int CF_SYM_LSB   = 11;
    localparam int CF_TOK_LSB   = 0;
    // ---------------------------------------------
    // Reset values
    // ---------------------------------------------
    localparam logic [3:0]  DIR_RST = 4'h0;
    localparam logic [1:0]  NET_RST = 2'h0;
    localparam logic [10:0] GAP_RST = 11'h000;
endpackage

// *** verif/switch_link_debug_control_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------
// Port checker
// ------------
module sldc_checker (
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        write_lock_i,
    input wire logic        debug_req_n_i,
    input wire logic        debug_req_n_oe_o,
    input wire logic        debug_mode_i,
    input wire logic        debug_call_trap_o,
    input wire logic [7:0]  link_credit_recv_i,
    input wire logic [7:0]  link_enable_o,
    input wire logic [7:0]  link_tx_allow_o,
    input wire logic [7:0]  link_greeting_token_o,
    input wire logic [7:0]  link_rx_reset_o,
    input wire logic [31:0] xl_direction_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Unlocked setup write
    wire logic cfg_wr = reg_wr_i && !write_lock_i && reg_addr_i[7:3] == 5'h10;
    property p_pull; debug_req_n_oe_o |-> debug_mode_i; endproperty
    a_pull: assert property (p_pull) else $error("pull outside debug");
    property p_rd_quiet; !$past(reg_rd_i) |-> reg_rdata_o == 32'h0; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("stray read data");
    property p_greet; (|link_greeting_token_o) == $past(cfg_wr && reg_wdata_i[24]); endproperty
    a_greet: assert property (p_greet) else $error("greeting pulse");
    property p_rxr; (|link_rx_reset_o) == $past(cfg_wr && reg_wdata_i[23]); endproperty
    a_rxr: assert property (p_rxr) else $error("rx reset pulse");
    property p_tx_gate; (link_tx_allow_o & ~link_enable_o) == 8'h0; endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("send while disabled");
    property p_greet_drop;
        (link_greeting_token_o & link_tx_allow_o & ~$past(link_credit_recv_i)) == 8'h0;
    endproperty
    a_greet_drop: assert property (p_greet_drop) else $error("credit kept");
    property p_trap;
        debug_call_trap_o |-> !$past(debug_req_n_i, 2) ##1 !debug_call_trap_o;
    endproperty
    a_trap: assert property (p_trap) else $error("stray trap");
    property p_lock;
        reg_wr_i && write_lock_i |=> $stable(link_enable_o) && $stable(xl_direction_o);
    endproperty
    a_lock: assert property (p_lock) else $error("locked write");
    c_greet: cover property (|link_greeting_token_o);
    c_trap: cover property (debug_call_trap_o);
    c_lock: cover property (reg_wr_i && write_lock_i);
endmodule // sldc_checker
bind switch_link_debug_control sldc_checker sldc_checker_inst (.*);
`default_nettype wire

// *** verif/link_peer_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------
// Remote link ends, one per external link
// ------------
module link_peer_model (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       slow_i,
    input  wire logic [7:0] greeting_i,
    input  wire logic [7:0] tx_allow_i,
    output logic      [7:0] credit_recv_o,
    output logic      [7:0] credit_spent_o
);
    int wait_q [8];  // Cycles to credit grant
    int use_q [8];   // Send cycles left on credit
    // Grant credit after a greeting, spend it while sending
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        for (int i = 0; i < 8; i++) begin
            credit_recv_o[i]  <= 1'b0;
            credit_spent_o[i] <= 1'b0;
            if (!rst_n_i) begin
                wait_q[i] <= 0;
                use_q[i]  <= 0;
            end else if (greeting_i[i]) begin
                wait_q[i] <= slow_i ? 20 : 2;
            end else if (wait_q[i] == 1) begin
                credit_recv_o[i] <= 1'b1;
                wait_q[i]        <= 0;
                use_q[i]         <= 8;
            end else if (wait_q[i] > 1) begin
                wait_q[i] <= wait_q[i] - 1;
            end else if (use_q[i] == 1) begin
                credit_spent_o[i] <= 1'b1;
                use_q[i]          <= 0;
            end else if (use_q[i] > 1 && tx_allow_i[i]) begin
                use_q[i] <= use_q[i] - 1;
            end
        end
    end
endmodule // link_peer_model
`default_nettype wire

// *** verif/switch_link_debug_control_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module switch_link_debug_control_tb;
    import switch_ctl_pkg::*;
    // ------------
    // Port signals
    // ------------
    logic ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i, write_lock_i, pin_drv, peer_slow;
    logic debug_req_n_out_o, debug_req_n_oe_o, debug_mode_i, tile_debug_i, debug_call_trap_o;
    logic [7:0]  reg_addr_i, xl_junk_i, xl_route_out_i, xl_route_in_i, pl_dest_type_i;
    logic [7:0]  link_err_i, link_credit_issued_i, link_credit_recv_i, link_credit_spent_i;
    logic [7:0]  link_enable_o, link_five_wire_o, link_tx_allow_o, pl_network_o;
    logic [7:0]  link_greeting_token_o, link_rx_reset_o;
    logic [3:0]  pl_junk_i, pl_route_out_i, pl_route_in_i;
    logic [15:0] xl_dest_type_i, xl_network_o;
    logic [31:0] reg_wdata_i, reg_rdata_o, xl_direction_o, pl_dest_num_i;
    logic [63:0] xl_dest_num_i;
    logic [87:0] link_sym_gap_o, link_tok_gap_o;
    wire logic   debug_req_n_i = debug_req_n_oe_o ? 1'b0 : pin_drv;  // Open drain
    // Reference model state
    logic [31:0] m_st [8], m_ps [4], m_cf [8], m_dbg, m_src;
    logic [7:0]  m_err, m_cred;
    int let_of [8] = '{2, 3, 1, 0, 6, 7, 4, 5};  // Slot to link letter
    int seed = 32'h2d6cfe57, err_count = 0, checks = 0, traps = 0, t0, l;
    switch_link_debug_control switch_link_debug_control_inst (.*);
    link_peer_model link_peer_model_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .slow_i(peer_slow), .greeting_i(link_greeting_token_o), .tx_allow_i(link_tx_allow_o),
        .credit_recv_o(link_credit_recv_i), .credit_spent_o(link_credit_spent_i));
    // Clock, trap counter
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) if (debug_call_trap_o === 1'b1) traps++;
    // ------------
    // Model and tasks
    // ------------
    function automatic logic [31:0] exp_rd(logic [7:0] a);
        int l, p;
        l = let_of[a[2:0]];
        p = a[1:0];
        if (a == 8'h10) return m_dbg;
        if (a == 8'h1f) return m_src;
        if (a[7:3] == 5'h04) return m_st[a[2:0]] | {6'h0, xl_dest_type_i[2*l+:2],
            xl_dest_num_i[8*l+:8], 13'h0, xl_junk_i[l], xl_route_out_i[l], xl_route_in_i[l]};
        if (a[7:2] == 6'h10) return m_ps[p] | {6'h0, pl_dest_type_i[2*p+:2],
            pl_dest_num_i[8*p+:8], 13'h0, pl_junk_i[p], pl_route_out_i[p], pl_route_in_i[p]};
        if (a[7:3] == 5'h10) return m_cf[a[2:0]] | {4'h0, m_err[l], link_credit_issued_i[l],
            m_cred[l], 25'h0};
        return 32'h0;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        if (write_lock_i) return;
        if (a == 8'h10) m_dbg = d & 32'h3;
        if (a == 8'h1f) m_src = d & 32'h11;
        if (a[7:3] == 5'h04) m_st[a[2:0]] = d & 32'hf30;
        if (a[7:2] == 6'h10) m_ps[a[1:0]] = d & 32'h30;
        if (a[7:3] == 5'h10) m_cf[a[2:0]] = d & 32'hc03fffff;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 cmp(reg_rdata_o, exp_rd(a));
        if (a[7:3] == 5'h10) m_err[let_of[a[2:0]]] = 1'b0;
    endtask
    task automatic wait_tx(input int l, input logic v);
        for (int k = 0; k < 60 && link_tx_allow_o[l] !== v; k++) begin
            @(posedge ref_clk_i);
            #1;
        end
        cmp(32'(link_tx_allow_o[l]), 32'(v));
    endtask
    task automatic rand_status(input int r);
        @(posedge ref_clk_i);
        xl_dest_type_i <= (16'($random(seed)) & 16'h5555) << r[0];
        pl_dest_type_i <= (8'($random(seed)) & 8'h55) << r[0];
        xl_dest_num_i  <= {$random(seed), $random(seed)};
        pl_dest_num_i  <= $random(seed);
        {xl_junk_i, xl_route_out_i, xl_route_in_i, link_credit_issued_i} <= $random(seed);
        {pl_junk_i, pl_route_out_i, pl_route_in_i} <= 12'($random(seed));
    endtask
    task automatic check_all();
        for (int s = 0; s < 8; s++) begin
            l = let_of[s];
            rd(8'h20 + 8'(s));
            rd(8'h80 + 8'(s));
            if (s < 4) rd(8'h40 + 8'(s));
            cmp(32'(xl_direction_o[4*l+:4]), 32'(m_st[s][11:8]));
            cmp(32'(xl_network_o[2*l+:2]), 32'(m_st[s][5:4]));
            cmp(32'(link_enable_o[l]), 32'(m_cf[s][31]));
            cmp(32'(link_five_wire_o[l]), 32'(m_cf[s][30]));
            cmp(32'(link_sym_gap_o[11*l+:11]), 32'(m_cf[s][21:11]));
            cmp(32'(link_tok_gap_o[11*l+:11]), 32'(m_cf[s][10:0]));
            if (s < 4) cmp(32'(pl_network_o[2*s+:2]), 32'(m_ps[s][5:4]));
        end
        rd(8'h10);
        rd(8'h1f);
    endtask
    task automatic wrap_up();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_count++;
        wrap_up();
    end
    // ------------
    // Test sequence
    // ------------
    initial begin
        {rst_n_i, reg_wr_i, reg_rd_i, write_lock_i, debug_mode_i, tile_debug_i} = 6'h0;
        {pin_drv, peer_slow, reg_addr_i, reg_wdata_i, link_err_i} = {1'b1, 49'h0};
        {xl_dest_type_i, xl_dest_num_i, xl_junk_i, xl_route_out_i, xl_route_in_i} = 104'h0;
        {pl_dest_type_i, pl_dest_num_i, pl_junk_i, pl_route_out_i, pl_route_in_i} = 52'h0;
        link_credit_issued_i = 8'h0;
        {m_dbg, m_src, m_err, m_cred} = 80'h0;
        for (int i = 0; i < 8; i++) {m_st[i], m_ps[i % 4], m_cf[i]} = 96'h0;
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 256; i++) rd(8'(i));
        $display("test reset_values done");
        for (int r = 0; r < 3; r++) begin
            rand_status(r);
            for (int s = 0; s < 8; s++) begin
                wr(8'h20 + 8'(s), $random(seed));
                wr(8'h40 + 8'(s % 4), $random(seed));
                wr(8'h80 + 8'(s), $random(seed) & 32'hfe7fffff);
            end
            wr(8'h10, $random(seed));
            wr(8'h1f, $random(seed));
            check_all();
            @(posedge ref_clk_i);
            write_lock_i <= r[0];
            for (int s = 0; s < 8; s++) wr(8'h20 + 8'(s), $random(seed));
        end
        @(posedge ref_clk_i);
        write_lock_i <= 1'b0;
        check_all();
        $display("test config_and_lock done");
        for (int s = 0; s < 8; s++) begin
            l = let_of[s];
            @(posedge ref_clk_i);
            link_err_i  <= 8'h1 << l;
            peer_slow   <= s[0];
            @(posedge ref_clk_i);
            link_err_i <= 8'h0;
            m_err[l] = 1'b1;
            rd(8'h80 + 8'(s));
            rd(8'h80 + 8'(s));
            wr(8'h80 + 8'(s), m_cf[s] | 32'h81000000);
            #1 cmp(32'(link_greeting_token_o), 32'h1 << l);
            wait_tx(l, 1'b1);
            m_cred[l] = 1'b1;
            rd(8'h80 + 8'(s));
            wait_tx(l, 1'b0);
            m_cred[l] = 1'b0;
            rd(8'h80 + 8'(s));
            wr(8'h80 + 8'(s), m_cf[s] | 32'h00800000);
            #1 cmp(32'(link_rx_reset_o), 32'h1 << l);
        end
        $display("test link_setup done");
        wr(8'h10, 32'h2);
        wr(8'h1f, 32'h0);
        for (int k = 0; k < 2; k++) begin
            t0 = traps;
            pin_drv <= 1'b0;
            repeat (8) @(posedge ref_clk_i);
            pin_drv <= 1'b1;
            repeat (5) @(posedge ref_clk_i);
            cmp(32'(traps - t0), 32'(1 - k));
            if (k == 0) m_src = 32'h10;
            if (k == 0) rd(8'h1f);
            if (k == 0) wr(8'h10, 32'h0);
        end
        @(posedge ref_clk_i);
        tile_debug_i <= 1'b1;
        @(posedge ref_clk_i);
        tile_debug_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        m_src = 32'h1;
        rd(8'h1f);
        wr(8'h10, 32'h1);
        debug_mode_i <= 1'b1;
        @(posedge ref_clk_i);
        #1 cmp(32'({debug_req_n_oe_o, debug_req_n_out_o}), 32'h2);
        debug_mode_i <= 1'b0;
        $display("test debug_pin done");
        wrap_up();
    end
endmodule // switch_link_debug_control_tb
`default_nettype wire
